// >>> hw/pic_pkg.sv
package pic_pkg;

  localparam int PIC_NREG = 12;

  // Second-level register indices.
  localparam int PIC_IDX_CORE = 0;
  localparam int PIC_IDX_MON = 1;
  localparam int PIC_IDX_MISC = 2;
  localparam int PIC_IDX_MODE = 3;
  localparam int PIC_IDX_ILIM_BUCK = 4;
  localparam int PIC_IDX_ILIM_LIN = 5;
  localparam int PIC_IDX_UV_BUCK = 6;
  localparam int PIC_IDX_UV_LIN = 7;
  localparam int PIC_IDX_OV_BUCK = 8;
  localparam int PIC_IDX_OV_LIN = 9;
  localparam int PIC_IDX_BUTTON = 10;
  localparam int PIC_IDX_PIN = 11;

  // Register addresses on the internal register port.
  localparam logic [7:0] PIC_ADDR_SUMMARY = 8'h00;
  localparam logic [7:0] PIC_ADDR_LATCH_BASE = 8'h10;
  localparam logic [7:0] PIC_ADDR_MASK_BASE = 8'h20;
  localparam logic [7:0] PIC_ADDR_SENSE_BASE = 8'h30;
  localparam logic [7:0] PIC_ADDR_SHORT = 8'h40;
  localparam logic [7:0] PIC_ADDR_CMD = 8'h50;

  // Implemented latch and mask bits per register; others are reserved.
  localparam logic [7:0] PIC_LATCH_VALID [PIC_NREG] = '{
    8'hFF, 8'hFF, 8'h3F, 8'hDF, 8'h9F, 8'h07,
    8'hDF, 8'h0F, 8'hDF, 8'h0F, 8'h1F, 8'h3F};
  // Implemented sense bits per register.
  localparam logic [7:0] PIC_SENSE_VALID [PIC_NREG] = '{
    8'h03, 8'hFF, 8'h00, 8'h00, 8'h1F, 8'h07,
    8'hDF, 8'h0F, 8'hDF, 8'h0F, 8'h00, 8'h7F};
  // Everything starts masked except the power-up done latch.
  localparam logic [7:0] PIC_MASK_RESET [PIC_NREG] = '{
    8'hF7, 8'hFF, 8'h3F, 8'hDF, 8'h9F, 8'h07,
    8'hDF, 8'h0F, 8'hDF, 8'h0F, 8'h1F, 8'h3F};
  // Summary bit fed by each second-level register.
  localparam int PIC_GROUP [PIC_NREG] = '{0, 1, 1, 2, 3, 3, 4, 4, 5, 5, 6, 6};

  localparam int PIC_SUM_WARN = 7;
  localparam int PIC_MISC_BAD_CMD = 2;
  localparam int PIC_MISC_LOGIC_DONE = 1;
  localparam int PIC_PULSE_RESET = 0;
  localparam int PIC_PULSE_IRQ = 1;

  // System command codes.
  localparam logic [7:0] PIC_CMD_TURN_OFF = 8'hA5;
  localparam logic [7:0] PIC_CMD_SW_RESET = 8'h3E;
  localparam logic [7:0] PIC_CMD_ANALOG_TEST = 8'h55;
  localparam logic [7:0] PIC_CMD_LOGIC_TEST = 8'h4A;
  localparam logic [7:0] PIC_CMD_RESET_PULSE = 8'h9C;
  localparam logic [7:0] PIC_CMD_IRQ_PULSE = 8'h75;
  localparam logic [7:0] PIC_CMD_TO_FAULT = 8'hB3;
  localparam logic [7:0] PIC_CMD_TO_EXTERNAL_RESET_IN = 8'hBA;
  localparam logic [7:0] PIC_CMD_STANDBY = 8'h2C;

  // Test pulse: nominal 100 us, allowed 90 to 110 us.
  localparam int PIC_PULSE_NS = 100_000;
  localparam int PIC_CLK_PERIOD_NS = 10;
  localparam int PIC_PULSE_CYCLES = PIC_PULSE_NS / PIC_CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pic_reg_req_t;

  typedef struct packed {
    logic reset_out;
    logic failsafe_out;
    logic power_good;
    logic [3:0] gpio;
    logic [1:0] fault_collect;
  } pic_pin_t;

  typedef struct packed {
    logic turn_off;
    logic sw_reset;
    logic standby;
    logic analog_self_test;
    logic logic_self_test;
  } pic_cmd_t;

endpackage

// >>> hw/pic_irq_cmd_unit.sv
// Notes on behaviour
// - latch 1 means captured, mask 1 blocks the pin, sense 1 means present now.
// - pin sense bits give the sampled pin level, 0 low, 1 high.
// - live sense for reset, fail-safe, power-good, four GPIOs, two fault inputs.
// - command 0xA5 turns off, 0x3E resets, 0x2C requests standby.
// - command 0x55 starts analog self-test, 0x4A starts logic self-test.
// - 0xB3 selects fault-collection use, 0xBA returns to external-reset use.
// - 0x9C drives a 90 to 110 us low pulse on the reset output.
// - 0x75 drives a 90 to 110 us low pulse on the interrupt output.
// - undefined command codes do nothing but set the bad-command latch.
// - bad-command latch pulls the interrupt low only while unmasked.
// - summary bits 7..0: warning, pins, OV, UV, ILIM, mode, monitor, core.
// - core latches 7..0: shutdown, freq ready, dyn check, checksum, up, down...
// - monitor bits 3..0 thermal 155..110, above them clock, bandgap, supply OV.
// - misc bit 2 bad command, bit 1 logic test done, bits 7 and 6 unused.
// - button-hold latches for 8, 4, 3, 2, 1 seconds in bits 4..0.
// - short sense bits 7,6 are two GPIO levels, below them pin shorts.
// - interrupt output low is the OR of all unmasked second-level latches, the shutdown warning and the 0x75 pulse.
// - a latch stays set until written with 1; writing 0 leaves it.
// - summary bit follows its group's unmasked latches and clears by itself.
// - shutdown warning has no mask and always asserts the interrupt.
`timescale 1ns/1ps
module pic_irq_cmd_unit
  import pic_pkg::*;
#(
  parameter int PULSE_CYCLES = PIC_PULSE_CYCLES,
  parameter logic FAULT_COLLECT_AT_RESET = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire pic_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [PIC_NREG-1:0][7:0] event_in,
  input wire logic [PIC_NREG-1:0][7:0] sense_in,
  input wire logic shutdown_warning,
  input wire pic_pin_t pin_level_raw,
  input wire logic [5:0] pin_short_raw,
  output logic irq_out_n,
  output logic reset_out_n,
  output pic_cmd_t cmd_pulse,
  output logic fault_collect_mode
);

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES - 1);

  logic [7:0] latch_q [PIC_NREG];
  logic [7:0] mask_q [PIC_NREG];
  logic [PIC_NREG-1:0] pend;
  logic [7:0] summary;
  pic_pin_t pin_meta_q;
  pic_pin_t pin_sync_q;
  logic [5:0] short_meta_q;
  logic [5:0] short_sync_q;
  logic bad_cmd_q;
  logic [1:0] pulse_req;
  logic [1:0] pulse_n_q;
  logic [CNT_W-1:0] pulse_cnt_q [2];
  logic cmd_wr;
  logic [7:0] pin_sense;
  logic [7:0] short_sense;
  logic [7:0] rd_d;

  assign cmd_wr = reg_req.wr && (reg_req.addr == PIC_ADDR_CMD);

  // Pin levels and short comparators are asynchronous to clk_sys.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      short_meta_q <= '0;
      short_sync_q <= '0;
    end else if (ce) begin
      pin_meta_q <= pin_level_raw;
      pin_sync_q <= pin_meta_q;
      short_meta_q <= pin_short_raw;
      short_sync_q <= short_meta_q;
    end
  end

  // Pin level sense layout: bit 7 unused, then gpio3, gpio2, fault inputs,
  // power-good, fail-safe, reset.
  assign pin_sense = {1'b0, pin_sync_q.gpio[3], pin_sync_q.gpio[2],
                      pin_sync_q.fault_collect[1], pin_sync_q.fault_collect[0],
                      pin_sync_q.power_good, pin_sync_q.failsafe_out,
                      pin_sync_q.reset_out};
  assign short_sense = {pin_sync_q.gpio[1], pin_sync_q.gpio[0],
                        short_sync_q};

  // Per-register latch and mask.
  for (genvar g = 0; g < PIC_NREG; g++) begin : g_reg
    logic [7:0] set_v;
    logic [7:0] clr_v;

    always_comb begin
      set_v = event_in[g];
      if (g == PIC_IDX_MISC) begin
        set_v[PIC_MISC_BAD_CMD] = event_in[g][PIC_MISC_BAD_CMD] | bad_cmd_q;
      end
      clr_v = '0;
      if (reg_req.wr && (reg_req.addr == PIC_ADDR_LATCH_BASE + 8'(g))) begin
        clr_v = reg_req.wdata;
      end
    end

    // An event in the clearing cycle wins, so nothing is lost.
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        latch_q[g] <= '0;
      end else if (ce) begin
        latch_q[g] <= PIC_LATCH_VALID[g]
                      & ((latch_q[g] & ~clr_v) | set_v);
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        mask_q[g] <= PIC_MASK_RESET[g];
      end else if (ce && reg_req.wr
                   && reg_req.addr == PIC_ADDR_MASK_BASE + 8'(g)) begin
        mask_q[g] <= reg_req.wdata & PIC_LATCH_VALID[g];
      end
    end

    assign pend[g] = |(latch_q[g] & ~mask_q[g]);
  end

  // Summary is derived, never stored, so it clears as soon as its group does.
  always_comb begin
    summary = '0;
    for (int i = 0; i < PIC_NREG; i++) begin
      summary[PIC_GROUP[i]] = summary[PIC_GROUP[i]] | pend[i];
    end
    summary[PIC_SUM_WARN] = shutdown_warning;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_out_n <= 1'b1;
    end else if (ce) begin
      irq_out_n <= ~((|summary) | ~pulse_n_q[PIC_PULSE_IRQ]);
    end
  end

  assign reset_out_n = pulse_n_q[PIC_PULSE_RESET];

  // Command decode; every code outside the table only flags bad command.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cmd_pulse <= '0;
      bad_cmd_q <= 1'b0;
      pulse_req <= '0;
      fault_collect_mode <= FAULT_COLLECT_AT_RESET;
    end else if (ce) begin
      cmd_pulse <= '0;
      bad_cmd_q <= 1'b0;
      pulse_req <= '0;
      if (cmd_wr) begin
        unique case (reg_req.wdata)
          PIC_CMD_TURN_OFF: cmd_pulse.turn_off <= 1'b1;
          PIC_CMD_SW_RESET: cmd_pulse.sw_reset <= 1'b1;
          PIC_CMD_STANDBY: cmd_pulse.standby <= 1'b1;
          PIC_CMD_ANALOG_TEST: cmd_pulse.analog_self_test <= 1'b1;
          PIC_CMD_LOGIC_TEST: cmd_pulse.logic_self_test <= 1'b1;
          PIC_CMD_RESET_PULSE: pulse_req[PIC_PULSE_RESET] <= 1'b1;
          PIC_CMD_IRQ_PULSE: pulse_req[PIC_PULSE_IRQ] <= 1'b1;
          PIC_CMD_TO_FAULT: fault_collect_mode <= 1'b1;
          PIC_CMD_TO_EXTERNAL_RESET_IN: fault_collect_mode <= 1'b0;
          default: bad_cmd_q <= 1'b1;
        endcase
      end
    end
  end

  // Test pulses last exactly PULSE_CYCLES; a repeat request restarts one.
  for (genvar p = 0; p < 2; p++) begin : g_pulse
    always_ff @(posedge clk_sys) begin
      if (!rstn) begin
        pulse_n_q[p] <= 1'b1;
        pulse_cnt_q[p] <= '0;
      end else if (ce) begin
        if (pulse_req[p]) begin
          pulse_n_q[p] <= 1'b0;
          pulse_cnt_q[p] <= PULSE_LOAD;
        end else if (!pulse_n_q[p]) begin
          if (pulse_cnt_q[p] == '0) begin
            pulse_n_q[p] <= 1'b1;
          end else begin
            pulse_cnt_q[p] <= pulse_cnt_q[p] - 1'b1;
          end
        end
      end
    end
  end

  // Read mux; reading changes no state.
  always_comb begin
    rd_d = '0;
    if (reg_req.addr == PIC_ADDR_SUMMARY) begin
      rd_d = summary;
    end else if (reg_req.addr == PIC_ADDR_SHORT) begin
      rd_d = short_sense;
    end
    for (int i = 0; i < PIC_NREG; i++) begin
      if (reg_req.addr == PIC_ADDR_LATCH_BASE + 8'(i)) begin
        rd_d = latch_q[i];
      end
      if (reg_req.addr == PIC_ADDR_MASK_BASE + 8'(i)) begin
        rd_d = mask_q[i];
      end
      if (reg_req.addr == PIC_ADDR_SENSE_BASE + 8'(i)) begin
        rd_d = (i == PIC_IDX_PIN) ? pin_sense
                                  : (sense_in[i] & PIC_SENSE_VALID[i]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_d;
      end
    end
  end

endmodule

// >>> dv/pic_irq_cmd_unit_properties.sv
`timescale 1ns/1ps
module pic_chk_props
  import pic_pkg::*;
#(
  parameter int PULSE_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire pic_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic shutdown_warning,
  input wire logic irq_out_n,
  input wire logic reset_out_n,
  input wire pic_cmd_t cmd_pulse,
  input wire logic fault_collect_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic cw;
  logic [15:0] low_q;
  assign cw = ce && reg_req.wr && reg_req.addr == PIC_ADDR_CMD;
  // A stretch counter, because the pulse is far longer than a repetition.
  always_ff @(posedge clk_sys) begin
    if (!rstn || reset_out_n) begin
      low_q <= 16'h0000;
    end else if (ce) begin
      low_q <= low_q + 16'h0001;
    end
  end
  property p_rd; ce && reg_req.rd |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_off;
    cw && reg_req.wdata == PIC_CMD_TURN_OFF |=> cmd_pulse.turn_off;
  endproperty
  a_off: assert property (p_off) else $error("no turn off");
  property p_lt;
    cw && reg_req.wdata == PIC_CMD_LOGIC_TEST |=> cmd_pulse.logic_self_test;
  endproperty
  a_lt: assert property (p_lt) else $error("no logic test");
  property p_fc;
    cw && reg_req.wdata == PIC_CMD_TO_FAULT |=> fault_collect_mode;
  endproperty
  a_fc: assert property (p_fc) else $error("no fault mode");
  property p_xr;
    cw && reg_req.wdata == PIC_CMD_TO_EXTERNAL_RESET_IN |=> !fault_collect_mode;
  endproperty
  a_xr: assert property (p_xr) else $error("no reset mode");
  property p_rp;
    cw && reg_req.wdata == PIC_CMD_RESET_PULSE |=> ##1 !reset_out_n;
  endproperty
  a_rp: assert property (p_rp) else $error("no reset pulse");
  property p_rl; $rose(reset_out_n) |-> low_q == 16'(PULSE_CYCLES); endproperty
  a_rl: assert property (p_rl) else $error("bad pulse length");
  property p_ip;
    cw && reg_req.wdata == PIC_CMD_IRQ_PULSE |=> ##2 !irq_out_n;
  endproperty
  a_ip: assert property (p_ip) else $error("no irq pulse");
  property p_warn; shutdown_warning |=> !irq_out_n; endproperty
  a_warn: assert property (p_warn) else $error("warn not on irq");
endmodule

bind pic_irq_cmd_unit pic_chk_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .shutdown_warning(shutdown_warning), .irq_out_n(irq_out_n),
  .reset_out_n(reset_out_n), .cmd_pulse(cmd_pulse),
  .fault_collect_mode(fault_collect_mode));

// >>> dv/pic_host_model.sv
`timescale 1ns/1ps
module pic_host_model
  import pic_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output pic_reg_req_t reg_req
);
  initial reg_req = '0;
  // Each access opens with its own falling edge so that a strobe is never
  // dropped and raised again in one time step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req <= {1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    @(negedge clk_sys);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    reg_req <= '0;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 3) begin
      @(negedge clk_sys);
      i++;
    end
    ok = reg_rvalid === 1'b1;
    d = reg_rdata;
  endtask
endmodule

// >>> dv/pic_irq_cmd_unit_tb_top.sv
`timescale 1ns/1ps
module pic_irq_cmd_unit_tb_top;
  import pic_pkg::*;
  localparam int PC = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  pic_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [PIC_NREG-1:0][7:0] event_in = '0;
  logic [PIC_NREG-1:0][7:0] sense_in = '0;
  logic shutdown_warning = 1'b0;
  pic_pin_t pin_level_raw = '0;
  logic [5:0] pin_short_raw = 6'h00;
  logic irq_out_n;
  logic reset_out_n;
  logic fault_collect_mode;
  pic_cmd_t cmd_pulse;
  logic [7:0] codes [5];
  int failures = 0;
  int num_checks = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  pic_irq_cmd_unit #(.PULSE_CYCLES(PC)) uut (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .event_in(event_in), .sense_in(sense_in),
    .shutdown_warning(shutdown_warning), .pin_level_raw(pin_level_raw),
    .pin_short_raw(pin_short_raw), .irq_out_n(irq_out_n),
    .reset_out_n(reset_out_n), .cmd_pulse(cmd_pulse),
    .fault_collect_mode(fault_collect_mode));
  pic_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_req(reg_req));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  task automatic irq(logic [7:0] e);
    chk("irq pin", {8'h00, e}, {15'h0000, irq_out_n});
  endtask
  task automatic plen(logic [7:0] c, bit on_irq);
    host.wr(PIC_ADDR_CMD, c);
    n = 0;
    while ((on_irq ? irq_out_n : reset_out_n) !== 1'b0 && n < 5) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    while ((on_irq ? irq_out_n : reset_out_n) === 1'b0 && n < 200) begin
      n++;
      @(negedge clk_sys);
    end
    chk("pulse cycles", 16'(PC), 16'(n));
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
  initial begin
    codes = '{PIC_CMD_TURN_OFF, PIC_CMD_SW_RESET, PIC_CMD_STANDBY,
      PIC_CMD_ANALOG_TEST, PIC_CMD_LOGIC_TEST};
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    rchk("core mask", PIC_ADDR_MASK_BASE, 8'hF7);
    irq(8'h01);
    event_in[PIC_IDX_CORE] = 8'h08;
    @(negedge clk_sys);
    event_in[PIC_IDX_CORE] = 8'h00;
    repeat (2) @(negedge clk_sys);
    irq(8'h00);
    rchk("summary", PIC_ADDR_SUMMARY, 8'h01);
    rchk("core latch", PIC_ADDR_LATCH_BASE, 8'h08);
    host.wr(PIC_ADDR_LATCH_BASE, 8'hF7);
    rchk("core latch", PIC_ADDR_LATCH_BASE, 8'h08);
    host.wr(PIC_ADDR_LATCH_BASE, 8'h08);
    rchk("summary", PIC_ADDR_SUMMARY, 8'h00);
    irq(8'h01);
    $display("test latch done");
    host.wr(PIC_ADDR_CMD, 8'h00);
    repeat (3) @(negedge clk_sys);
    rchk("misc latch", PIC_ADDR_LATCH_BASE + 8'h02, 8'h04);
    irq(8'h01);
    host.wr(PIC_ADDR_MASK_BASE + 8'h02, 8'hFB);
    rchk("misc mask", PIC_ADDR_MASK_BASE + 8'h02, 8'h3B);
    irq(8'h00);
    rchk("summary", PIC_ADDR_SUMMARY, 8'h02);
    host.wr(PIC_ADDR_LATCH_BASE + 8'h02, 8'h04);
    for (int i = 0; i < 5; i++) begin
      host.wr(PIC_ADDR_CMD, codes[i]);
      chk("cmd pulse", 16'(5'h10 >> i), 16'(cmd_pulse));
    end
    host.wr(PIC_ADDR_CMD, PIC_CMD_TO_FAULT);
    chk("fault mode", 16'h0001, {15'h0000, fault_collect_mode});
    host.wr(PIC_ADDR_CMD, PIC_CMD_TO_EXTERNAL_RESET_IN);
    chk("fault mode", 16'h0000, {15'h0000, fault_collect_mode});
    plen(PIC_CMD_RESET_PULSE, 1'b0);
    plen(PIC_CMD_IRQ_PULSE, 1'b1);
    $display("test commands done");
    pin_level_raw = 9'h166;
    pin_short_raw = 6'h2D;
    sense_in[PIC_IDX_CORE] = 8'hFF;
    repeat (3) @(negedge clk_sys);
    rchk("pin sense", PIC_ADDR_SENSE_BASE + 8'h0B, 8'h55);
    rchk("short sense", PIC_ADDR_SHORT, 8'h6D);
    rchk("core sense", PIC_ADDR_SENSE_BASE, 8'h03);
    rchk("unmapped", 8'h7F, 8'h00);
    // A write made while the clock enable is low must not be taken.
    ce = 1'b0;
    host.wr(PIC_ADDR_MASK_BASE, 8'h00);
    ce = 1'b1;
    rchk("core mask frozen", PIC_ADDR_MASK_BASE, 8'hF7);
    shutdown_warning = 1'b1;
    repeat (2) @(negedge clk_sys);
    irq(8'h00);
    rchk("summary", PIC_ADDR_SUMMARY, 8'h80);
    $display("test sense done");
    finish_test();
  end
endmodule
